//--- core/mps_pkg.sv
// Shared constants of the mixer position supervisor.
package mps_pkg;

    // ==========================================================
    // Widths and timing
    localparam int POS_W          = 12;
    localparam int CLK_MHZ        = 250;
    localparam int ACK_HOLD_MS    = 100;
    localparam int ACK_HOLD_CYCLES = ACK_HOLD_MS * 1000 * CLK_MHZ;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_MANUAL   = 8'h04;
    localparam logic [7:0] OFS_POS_BASE = 8'h08;
    localparam logic [7:0] OFS_TOL      = 8'h20;
    localparam logic [7:0] OFS_FTIME    = 8'h24;
    localparam logic [7:0] OFS_TEMPMAX  = 8'h28;
    localparam logic [7:0] OFS_STATUS   = 8'h2C;
    localparam logic [7:0] OFS_TARGET   = 8'h30;

    // ==========================================================
    // Modes and fixed position slots
    localparam logic [1:0] MODE_MANUAL  = 2'h0;
    localparam logic [1:0] MODE_AUTO    = 2'h1;
    localparam logic [1:0] MODE_AUTOPAR = 2'h2;
    localparam logic [1:0] KIND_START   = 2'h0;
    localparam logic [1:0] KIND_RUN     = 2'h1;
    localparam logic [1:0] KIND_LOW     = 2'h2;
    localparam int         POS_SLOTS    = 6;

    // ==========================================================
    // Synchronised input bit positions
    localparam int IN_ACK  = 0;
    localparam int IN_MISF = 1;
    localparam int IN_GAS  = 2;
    localparam int IN_MAIN = 3;
    localparam int IN_GEN  = 4;
    localparam int IN_RUN  = 5;
    localparam int IN_W    = 6;

    // ==========================================================
    // Reset values
    localparam logic [1:0]  RST_MODE    = 2'h0;
    localparam logic [11:0] RST_POS     = 12'h000;
    localparam logic [11:0] RST_TOL     = 12'h010;
    localparam logic [31:0] RST_FTIME   = 32'h00FF_FFFF;
    localparam logic [11:0] RST_TEMPMAX = 12'hFFF;

endpackage : mps_pkg

//--- core/mps_persist_if.sv
// Carrier between a persistence timer and its user.
`timescale 1ns/100ps
interface mps_persist_if #(parameter int W = 32);
    logic         level;
    logic [W-1:0] limit;
    logic         expired;
    modport timer (input level, input limit, output expired);
    modport user  (output level, output limit, input expired);
endinterface : mps_persist_if

//--- core/mps_sync.sv
// Two-flop synchroniser for asynchronous plant inputs.
`timescale 1ns/100ps
module mps_sync #(
    parameter int W = 6
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } mps_sync_s;

    mps_sync_s syncReg;
    mps_sync_s syncNext;

    if (W < 1)
    begin : g_chk
        $error("mps_sync width must be positive.");
    end

    always_comb
    begin
        syncNext.stage1 = asyncIn;
        syncNext.stage2 = syncReg.stage1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            syncReg <= '0;
        else
            syncReg <= syncNext;
    end

    assign syncOut = syncReg.stage2;
endmodule : mps_sync

//--- core/mps_persist.sv
// Counts how long a level has stood without a break.
`timescale 1ns/100ps
module mps_persist #(
    parameter int W = 32
) (
    input  wire logic      clk,
    input  wire logic      rst,
    mps_persist_if.timer   pif
);
    typedef struct packed {
        logic [W-1:0] count;
    } mps_persist_s;

    mps_persist_s perReg;
    mps_persist_s perNext;

    if (W < 2)
    begin : g_chk
        $error("mps_persist width too small.");
    end

    // Saturates at the limit so a long closure never wraps and re-fires.
    always_comb
    begin
        perNext = perReg;
        if (!pif.level)
            perNext.count = '0;
        else if (perReg.count < pif.limit)
            perNext.count = perReg.count + W'(1);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            perReg <= '0;
        else
            perReg <= perNext;
    end

    assign pif.expired = pif.level && (perReg.count >= pif.limit);
endmodule : mps_persist

//--- core/mps_top.sv
// Mixer position supervisor with its AHB-Lite register file.
//
// Our own choices: register access over AHB-Lite and the address map.
`timescale 1ns/100ps

// ==========================================================
module mps_top #(
    parameter int ACK_HOLD_CYCLES = mps_pkg::ACK_HOLD_CYCLES
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic      [31:0]              hrdata,
    output logic                          hreadyout,
    output logic                          hresp,
    input  wire logic                     alarmResetIn,
    input  wire logic                     misfireIn,
    input  wire logic                     gasSelectIn,
    input  wire logic                     mainsBreakerClosed,
    input  wire logic                     generatorBreakerClosed,
    input  wire logic                     engineRunIn,
    input  wire logic [mps_pkg::POS_W-1:0] mixerFeedbackIn,
    input  wire logic [mps_pkg::POS_W-1:0] intakeTempIn,
    input  wire logic                     powerInRangeIn,
    input  wire logic [mps_pkg::POS_W-1:0] powerTargetIn,
    output logic      [mps_pkg::POS_W-1:0] mixerTargetOut,
    output logic                          driveCloseOut,
    output logic                          driveOpenOut,
    output logic                          powerCtrlActiveOut,
    output logic                          mixerFaultOut,
    output logic                          intakeTempAlarmOut,
    output logic                          misfireDetectedOut,
    output logic                          errorAckPulseOut
);
    localparam int PW = mps_pkg::POS_W;

    typedef struct packed {
        logic [1:0]                   mode;
        logic [mps_pkg::POS_SLOTS-1:0][PW-1:0] pos;
        logic [PW-1:0]                manualPos;
        logic [PW-1:0]                tol;
        logic [31:0]                  faultTime;
        logic [PW-1:0]                tempMax;
        logic [PW-1:0]                target;
        logic                         driveClose;
        logic                         driveOpen;
        logic                         pwrActive;
        logic                         fault;
        logic                         tempAlarm;
        logic                         misfire;
        logic                         island;
        logic                         ackSeen;
        logic                         ackPulse;
        logic                         wrPend;
        logic [7:0]                   wrAddr;
        logic [31:0]                  rdata;
        logic [31:0]                  ackRun;
    } mps_state_s;

    mps_state_s stReg;
    mps_state_s stNext;

    logic [mps_pkg::IN_W-1:0] syn;
    logic                     autoMode;
    logic                     powerAllowed;
    logic                     aboveTol;
    logic                     belowTol;
    logic                     accept;
    logic [PW-1:0]            startPos;
    logic [PW-1:0]            runPos;
    logic [PW-1:0]            lowPos;

    mps_persist_if #(.W(32)) ackIf ();
    mps_persist_if #(.W(32)) faultIf ();

    if (ACK_HOLD_CYCLES < 1)
    begin : g_chk
        $error("ACK_HOLD_CYCLES must be at least one.");
    end

    // ==========================================================
    // Input synchronisation and persistence timers
    mps_sync #(.W(mps_pkg::IN_W)) u_sync (
        .clk     (clk),
        .rst     (rst),
        .asyncIn ({engineRunIn, generatorBreakerClosed, mainsBreakerClosed,
                   gasSelectIn, misfireIn, alarmResetIn}),
        .syncOut (syn)
    );

    assign ackIf.level   = syn[mps_pkg::IN_ACK];
    assign ackIf.limit   = 32'(ACK_HOLD_CYCLES);
    assign faultIf.level = aboveTol || belowTol;
    assign faultIf.limit = stReg.faultTime;

    mps_persist #(.W(32)) u_ack (
        .clk (clk),
        .rst (rst),
        .pif (ackIf)
    );

    mps_persist #(.W(32)) u_fault (
        .clk (clk),
        .rst (rst),
        .pif (faultIf)
    );

    // ==========================================================
    // Helpers
    function automatic logic [PW-1:0] posOf(
        input mps_state_s s,
        input logic       setTwo,
        input logic [1:0] kind
    );
        logic [2:0] idx;
        idx = (setTwo ? 3'h3 : 3'h0) + {1'b0, kind};
        return s.pos[idx];
    endfunction : posOf

    function automatic logic [31:0] regRead(
        input mps_state_s s,
        input logic [7:0] a
    );
        logic [31:0] d;
        d = 32'h0000_0000;
        if (a == mps_pkg::OFS_CTRL)
            d = {30'h0, s.mode};
        else if (a == mps_pkg::OFS_MANUAL)
            d = {20'h0, s.manualPos};
        else if (a >= mps_pkg::OFS_POS_BASE && a < mps_pkg::OFS_TOL)
            d = {20'h0, s.pos[3'((a - mps_pkg::OFS_POS_BASE) >> 2)]};
        else if (a == mps_pkg::OFS_TOL)
            d = {20'h0, s.tol};
        else if (a == mps_pkg::OFS_FTIME)
            d = s.faultTime;
        else if (a == mps_pkg::OFS_TEMPMAX)
            d = {20'h0, s.tempMax};
        else if (a == mps_pkg::OFS_STATUS)
            d = {24'h0, s.island, s.misfire, s.tempAlarm, s.fault,
                 s.pwrActive, s.driveOpen, s.driveClose, 1'b0};
        else if (a == mps_pkg::OFS_TARGET)
            d = {20'h0, s.target};
        return d;
    endfunction : regRead

    // ==========================================================
    // Position decisions
    assign autoMode     = stReg.mode == mps_pkg::MODE_AUTO
                       || stReg.mode == mps_pkg::MODE_AUTOPAR;
    assign powerAllowed = stReg.mode == mps_pkg::MODE_AUTO
                       || (stReg.mode == mps_pkg::MODE_AUTOPAR
                           && syn[mps_pkg::IN_MAIN]);
    assign startPos     = posOf(stReg, syn[mps_pkg::IN_GAS], mps_pkg::KIND_START);
    assign runPos       = posOf(stReg, syn[mps_pkg::IN_GAS], mps_pkg::KIND_RUN);
    assign lowPos       = posOf(stReg, syn[mps_pkg::IN_GAS], mps_pkg::KIND_LOW);
    assign aboveTol     = {1'b0, mixerFeedbackIn}
                        > ({1'b0, stReg.target} + {1'b0, stReg.tol});
    assign belowTol     = ({1'b0, mixerFeedbackIn} + {1'b0, stReg.tol})
                        < {1'b0, stReg.target};
    assign accept       = hsel && htrans[1] && hready;

    always_comb
    begin
        stNext          = stReg;
        stNext.ackPulse = 1'b0;
        stNext.pwrActive = 1'b0;
        stNext.island   = stReg.mode == mps_pkg::MODE_AUTOPAR
                       && !syn[mps_pkg::IN_MAIN];
        if (!autoMode)
            stNext.target = stReg.manualPos;
        else if (!syn[mps_pkg::IN_RUN])
            stNext.target = startPos;
        else if (!syn[mps_pkg::IN_GEN])
            stNext.target = runPos;
        else if (powerAllowed && powerInRangeIn)
        begin
            stNext.target    = powerTargetIn;
            stNext.pwrActive = 1'b1;
        end
        else
            stNext.target = lowPos;

        stNext.driveClose = aboveTol;
        stNext.driveOpen  = belowTol;
        stNext.tempAlarm  = intakeTempIn > stReg.tempMax;
        stNext.misfire    = syn[mps_pkg::IN_MISF];

        // The acknowledge fires once per closure that lasts ACK_HOLD_CYCLES, however long it is held.
        stNext.ackSeen = ackIf.expired;
        if (ackIf.expired && !stReg.ackSeen)
            stNext.ackPulse = 1'b1;
        stNext.ackRun = syn[mps_pkg::IN_ACK]
                      ? (stReg.ackRun == 32'hFFFF_FFFF ? stReg.ackRun : stReg.ackRun + 32'h1)
                      : 32'h0;

        // A new fault in the acknowledge cycle stays set.
        if (faultIf.expired)
            stNext.fault = 1'b1;
        else if (stNext.ackPulse)
            stNext.fault = 1'b0;

        // Register bus: writes land in the data phase, reads are fetched early.
        stNext.wrPend = accept && hwrite;
        stNext.wrAddr = haddr[7:0];
        if (accept && !hwrite)
            stNext.rdata = regRead(stReg, haddr[7:0]);
        if (stReg.wrPend)
        begin
            if (stReg.wrAddr == mps_pkg::OFS_CTRL)
                stNext.mode = hwdata[1:0];
            else if (stReg.wrAddr == mps_pkg::OFS_MANUAL)
                stNext.manualPos = hwdata[PW-1:0];
            else if (stReg.wrAddr >= mps_pkg::OFS_POS_BASE && stReg.wrAddr < mps_pkg::OFS_TOL)
                stNext.pos[3'((stReg.wrAddr - mps_pkg::OFS_POS_BASE) >> 2)] = hwdata[PW-1:0];
            else if (stReg.wrAddr == mps_pkg::OFS_TOL)
                stNext.tol = hwdata[PW-1:0];
            else if (stReg.wrAddr == mps_pkg::OFS_FTIME)
                stNext.faultTime = hwdata;
            else if (stReg.wrAddr == mps_pkg::OFS_TEMPMAX)
                stNext.tempMax = hwdata[PW-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stReg           <= '0;
            stReg.mode      <= mps_pkg::RST_MODE;
            stReg.pos       <= {mps_pkg::POS_SLOTS{mps_pkg::RST_POS}};
            stReg.manualPos <= mps_pkg::RST_POS;
            stReg.tol       <= mps_pkg::RST_TOL;
            stReg.faultTime <= mps_pkg::RST_FTIME;
            stReg.tempMax   <= mps_pkg::RST_TEMPMAX;
        end
        else
            stReg <= stNext;
    end

    // ==========================================================
    // Outputs
    assign hrdata             = stReg.rdata;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign mixerTargetOut     = stReg.target;
    assign driveCloseOut      = stReg.driveClose;
    assign driveOpenOut       = stReg.driveOpen;
    assign powerCtrlActiveOut = stReg.pwrActive;
    assign mixerFaultOut      = stReg.fault;
    assign intakeTempAlarmOut = stReg.tempAlarm;
    assign misfireDetectedOut = stReg.misfire;
    assign errorAckPulseOut   = stReg.ackPulse;

    // ==========================================================
    // Assertions
    ack_hold_min_a: assert property (
        @(posedge clk) disable iff (rst)
        errorAckPulseOut |-> $past(stReg.ackRun) >= 32'(ACK_HOLD_CYCLES))
        else $error("Acknowledge fired before the hold time.");

    ack_clears_fault_a: assert property (
        @(posedge clk) disable iff (rst)
        $fell(mixerFaultOut) |-> errorAckPulseOut)
        else $error("Fault cleared without an acknowledge.");

    gas_set_a: assert property (
        @(posedge clk) disable iff (rst)
        (autoMode && !syn[mps_pkg::IN_RUN] && syn[mps_pkg::IN_GAS])
        |=> mixerTargetOut == $past(stReg.pos[3]))
        else $error("Start position not taken from set 2.");

    island_low_a: assert property (
        @(posedge clk) disable iff (rst)
        (stReg.mode == mps_pkg::MODE_AUTOPAR && !syn[mps_pkg::IN_MAIN]
         && syn[mps_pkg::IN_RUN] && syn[mps_pkg::IN_GEN])
        |=> mixerTargetOut == $past(lowPos) && !powerCtrlActiveOut)
        else $error("Island operation left the low position.");

    run_pos_a: assert property (
        @(posedge clk) disable iff (rst)
        (autoMode && syn[mps_pkg::IN_RUN] && !syn[mps_pkg::IN_GEN])
        |=> mixerTargetOut == $past(runPos))
        else $error("Run position not commanded.");

    start_pos_a: assert property (
        @(posedge clk) disable iff (rst)
        (autoMode && !syn[mps_pkg::IN_RUN]) |=> mixerTargetOut == $past(startPos))
        else $error("Start position not commanded.");

    manual_pos_a: assert property (
        @(posedge clk) disable iff (rst)
        (stReg.mode == mps_pkg::MODE_MANUAL)
        |=> mixerTargetOut == $past(stReg.manualPos) && !powerCtrlActiveOut)
        else $error("Manual mode did not follow the manual position.");

    pwr_active_a: assert property (
        @(posedge clk) disable iff (rst)
        powerCtrlActiveOut |-> $past(syn[mps_pkg::IN_RUN] && syn[mps_pkg::IN_GEN]
                                     && powerInRangeIn && powerAllowed))
        else $error("Power control flagged without its conditions.");

    drives_exclusive_a: assert property (
        @(posedge clk) disable iff (rst)
        !(driveCloseOut && driveOpenOut))
        else $error("Both drive outputs closed.");

    drive_close_a: assert property (
        @(posedge clk) disable iff (rst)
        {1'b0, $past(mixerFeedbackIn)} > {1'b0, $past(mixerTargetOut)} + {1'b0, $past(stReg.tol)}
        |-> driveCloseOut)
        else $error("Drive close missing above tolerance.");

    drive_open_a: assert property (
        @(posedge clk) disable iff (rst)
        $past(mixerFeedbackIn) + $past(stReg.tol) + 13'h1 <= $past(mixerTargetOut)
        |-> driveOpenOut)
        else $error("Drive open missing below tolerance.");

    fault_set_a: assert property (
        @(posedge clk) disable iff (rst)
        $rose(mixerFaultOut) |-> $past(faultIf.level))
        else $error("Fault raised without deviation.");

    temp_alarm_a: assert property (
        @(posedge clk) disable iff (rst)
        intakeTempAlarmOut == $past(intakeTempIn > stReg.tempMax))
        else $error("Temperature alarm wrong.");

    misfire_a: assert property (
        @(posedge clk) disable iff (rst)
        $rose(misfireIn) ##1 misfireIn[*2] |=> misfireDetectedOut)
        else $error("Misfire not passed on.");

    power_cover_c: cover property (@(posedge clk) disable iff (rst) $rose(powerCtrlActiveOut));
    fault_cover_c: cover property (@(posedge clk) disable iff (rst) $rose(mixerFaultOut));
    ack_cover_c:   cover property (@(posedge clk) disable iff (rst) errorAckPulseOut);
endmodule : mps_top

//--- test/mps_plant_model.sv
// Behavioural mixer actuator that follows the drive outputs of the supervisor.
`timescale 1ns/100ps
module mps_plant_model (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      driveCloseOut,
    input  wire logic                      driveOpenOut,
    input  wire logic                      moveEn,
    input  wire logic                      loadEn,
    input  wire logic [mps_pkg::POS_W-1:0] loadPos,
    output logic      [mps_pkg::POS_W-1:0] mixerFeedbackIn
);
    // ==========================================================
    // Actuator travel
    // A low moveEn stands for a stuck mixer, which is how a fault is provoked.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            mixerFeedbackIn <= 12'h000;
        else if (loadEn)
            mixerFeedbackIn <= loadPos;
        else if (moveEn && driveOpenOut)
            mixerFeedbackIn <= mixerFeedbackIn + 12'h001;
        else if (moveEn && driveCloseOut)
            mixerFeedbackIn <= mixerFeedbackIn - 12'h001;
    end
endmodule : mps_plant_model

//--- test/mixer_position_supervisor_tb.sv
// Self-checking bench of the mixer position supervisor.
`timescale 1ns/100ps
module mixer_position_supervisor_tb;
    logic clk, rst, hsel, hwrite, hready, hresp, moveEn, loadEn;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, ackIn, misfIn, gasIn, mainsIn, genIn, runIn, pirIn;
    logic [11:0] fb, tempIn, pwrTgt, tgt, loadPos;
    logic dClose, dOpen, pAct, fault, tAlarm, misfOut, ackPulse;
    int errorCnt = 0, nTests = 0, ackCnt = 0;
    assign hready = hreadyout;
    mps_top #(.ACK_HOLD_CYCLES(20)) mps_top_inst (.clk(clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .alarmResetIn(ackIn), .misfireIn(misfIn), .gasSelectIn(gasIn),
        .mainsBreakerClosed(mainsIn), .generatorBreakerClosed(genIn), .engineRunIn(runIn),
        .mixerFeedbackIn(fb), .intakeTempIn(tempIn), .powerInRangeIn(pirIn),
        .powerTargetIn(pwrTgt), .mixerTargetOut(tgt), .driveCloseOut(dClose),
        .driveOpenOut(dOpen), .powerCtrlActiveOut(pAct), .mixerFaultOut(fault),
        .intakeTempAlarmOut(tAlarm), .misfireDetectedOut(misfOut),
        .errorAckPulseOut(ackPulse));
    mps_plant_model mps_plant_model_inst (.clk(clk), .rst(rst), .driveCloseOut(dClose),
        .driveOpenOut(dOpen), .moveEn(moveEn), .loadEn(loadEn), .loadPos(loadPos),
        .mixerFeedbackIn(fb));
    // ==========================================================
    // Clock, counters and shared tasks
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (ackPulse === 1'b1) ackCnt++;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic printVerdict;
        $display("errors %0d of %0d comparisons", errorCnt, nTests);
        if (errorCnt == 0 && nTests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : printVerdict
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask : settle
    // Holds each phase until hready is seen high; read data is taken at the data-phase edge.
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask : ahb
    task automatic setFb(input logic [11:0] p);
        loadPos <= p;
        loadEn <= 1'b1;
        @(posedge clk);
        loadEn <= 1'b0;
    endtask : setFb
    // ==========================================================
    // Scenarios
    task automatic regDefaults;
        ahb(1'b0, 8'h20, 32'h0); check(rd, 32'h0000_0010);
        ahb(1'b0, 8'h24, 32'h0); check(rd, 32'h00FF_FFFF);
        ahb(1'b0, 8'h28, 32'h0); check(rd, 32'h0000_0FFF);
        ahb(1'b0, 8'h40, 32'h0); check(rd, 32'h0);
        ahb(1'b1, 8'h30, 32'h0000_0ABC);
        ahb(1'b0, 8'h30, 32'h0); check(rd, 32'h0);
    endtask : regDefaults
    task automatic manualMode;
        runIn <= 1'b1;
        genIn <= 1'b1;
        ahb(1'b1, 8'h04, 32'h0000_0123);
        settle(5); check(tgt, 12'h123);
        ahb(1'b1, 8'h00, 32'h0000_0003);
        settle(5); check(tgt, 12'h123);
    endtask : manualMode
    task automatic fixedPositions;
        for (int i = 0; i < 6; i++) ahb(1'b1, 8'h08 + 8'(4 * i), 32'h100 + 32'(16 * i));
        ahb(1'b1, 8'h00, 32'h1);
        pirIn <= 1'b0;
        for (int g = 0; g < 2; g++)
            for (int k = 0; k < 3; k++)
            begin
                gasIn <= g[0];
                runIn <= (k != 0);
                genIn <= (k != 1);
                settle(5);
                check(tgt, 12'h100 + 12'(16 * (g * 3 + k)));
            end
        ahb(1'b0, 8'h30, 32'h0); check(rd, 32'h0000_0150);
        gasIn <= 1'b0;
    endtask : fixedPositions
    task automatic powerControl;
        pirIn <= 1'b1;
        pwrTgt <= 12'h345;
        for (int m = 0; m < 2; m++)
        begin
            mainsIn <= m[0];
            settle(5); check({pAct, tgt}, 13'h1345);
        end
        ahb(1'b1, 8'h00, 32'h2);
        settle(5); check({pAct, tgt}, 13'h1345);
        mainsIn <= 1'b0;
        settle(5); check({pAct, tgt}, 13'h0120);
        ahb(1'b0, 8'h2C, 32'h0); check(rd & 32'h88, 32'h80);
        mainsIn <= 1'b1;
        pirIn <= 1'b0;
        settle(5); check({pAct, tgt}, 13'h0120);
    endtask : powerControl
    task automatic driveOutputs;
        logic [11:0] fbs[4] = '{12'h211, 12'h210, 12'h1EF, 12'h1F0};
        logic [1:0] exps[4] = '{2'h2, 2'h0, 2'h1, 2'h0};
        ahb(1'b1, 8'h00, 32'h0);
        ahb(1'b1, 8'h04, 32'h200);
        for (int i = 0; i < 4; i++)
        begin
            setFb(fbs[i]);
            settle(3); check({dClose, dOpen}, exps[i]);
        end
        setFb(12'h100);
        moveEn <= 1'b1;
        settle(300); check({dClose, dOpen}, 2'h0);
        moveEn <= 1'b0;
    endtask : driveOutputs
    task automatic faultAndAck;
        int c0;
        setFb(12'h200);
        ahb(1'b1, 8'h24, 32'h0000_000A);
        setFb(12'h400);
        settle(5); check(fault, 1'b0);
        settle(15); check(fault, 1'b1);
        c0 = ackCnt;
        ackIn <= 1'b1;
        settle(10);
        ackIn <= 1'b0;
        settle(10); check({fault, 8'(ackCnt - c0)}, 9'h100);
        setFb(12'h200);
        ackIn <= 1'b1;
        settle(40);
        ackIn <= 1'b0;
        settle(5); check({fault, 8'(ackCnt - c0)}, 9'h001);
    endtask : faultAndAck
    task automatic tempAndMisfire;
        ahb(1'b1, 8'h28, 32'h500);
        tempIn <= 12'h501;
        settle(3); check(tAlarm, 1'b1);
        tempIn <= 12'h500;
        settle(3); check(tAlarm, 1'b0);
        misfIn <= 1'b1;
        settle(5); check(misfOut, 1'b1);
        misfIn <= 1'b0;
        settle(5); check(misfOut, 1'b0);
    endtask : tempAndMisfire
    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h0; ackIn = 1'b0; misfIn = 1'b0; gasIn = 1'b0;
        mainsIn = 1'b0; genIn = 1'b0; runIn = 1'b0; pirIn = 1'b0; tempIn = 12'h000;
        pwrTgt = 12'h000; moveEn = 1'b0; loadEn = 1'b0; loadPos = 12'h000;
        settle(2);
        rst <= 1'b0;
        @(posedge clk);
        regDefaults();
        manualMode();
        fixedPositions();
        powerControl();
        driveOutputs();
        faultAndAck();
        tempAndMisfire();
        printVerdict();
    end
    initial
    begin
        settle(20000);
        errorCnt++;
        printVerdict();
    end
endmodule : mixer_position_supervisor_tb
